//--- design/ehg_params.svh
// Constants for the health-gated entropy output block
// Operation
// - Total-failure check runs at start-up before any word is released.
// - Physical mode: after total failure flagged, no words are released.
// - Failure during operation suppresses words holding bits after failure.
// - Online test examines raw bits at start-up and during operation.
// - No output until power-up online test has passed.
// - Online defect flagged stops all word release.
// - Online test runs continuously and scans every raw bit.
// - Each random number is delivered as a 32-bit word.
// - Entropy per bit exceeds 0.997; words look ideal to consumers.
// - Hybrid mode: same start-up total-failure check and output block.
// - Hybrid mode: also wait for post-processing seeding to finish.
// - Hybrid post-processing never outputs faster than raw input arrives.
`ifndef EHG_PARAMS_SVH
`define EHG_PARAMS_SVH

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define EHG_WORD_W        32
`define EHG_CNT_W         8
`define EHG_STUCK_LIMIT   8'h20
`define EHG_WIN_BITS      8'hff
`define EHG_ONES_LO       8'h50
`define EHG_ONES_HI       8'haf
`define EHG_SEED_WORDS    8'h08
`define EHG_TEST_WINDOWS  8'h02

`endif

//--- design/ehg_pkg.sv
// Types for the health-gated entropy output block
package ehg_pkg;
	typedef enum logic [1:0] {
		EHG_ST_STARTUP,
		EHG_ST_SEED,
		EHG_ST_RUN,
		EHG_ST_BLOCKED
	} ehg_state_e;
endpackage : ehg_pkg

//--- design/ehg_health_if.sv
// Bundle between the gate controller and the health tester
`timescale 1ns/1ps
interface ehg_health_if;
	logic bit_vld;
	logic bit_val;
	logic total_fail;
	logic defect;
	logic win_pass;
	modport ctrl (output bit_vld, output bit_val,
		input total_fail, input defect, input win_pass);
	modport test (input bit_vld, input bit_val,
		output total_fail, output defect, output win_pass);
endinterface : ehg_health_if

//--- design/ehg_health.sv
// Total-failure and online statistical test on the raw bit stream
`timescale 1ns/1ps
`include "ehg_params.svh"
module ehg_health (
	input  wire logic  clk_i,
	input  wire logic  rst_n,
	ehg_health_if.test hif
);
	// ----------------------------------------
	// Counters
	// ----------------------------------------
	logic [`EHG_CNT_W-1:0] run_r;
	logic [`EHG_CNT_W-1:0] bits_r;
	logic [`EHG_CNT_W-1:0] ones_r;
	logic                  prev_r;
	logic                  tf_r;
	logic                  df_r;
	logic                  pass_r;

	wire same_w    = hif.bit_val == prev_r;
	wire stuck_w   = same_w && (run_r >= `EHG_STUCK_LIMIT - 8'h01);
	wire win_end_w = bits_r == `EHG_WIN_BITS - 8'h01;
	wire [`EHG_CNT_W-1:0] ones_nxt = ones_r + {7'h00, hif.bit_val};
	wire bad_win_w = (ones_nxt < `EHG_ONES_LO) || (ones_nxt > `EHG_ONES_HI);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			run_r  <= 8'h00;
			bits_r <= 8'h00;
			ones_r <= 8'h00;
			prev_r <= 1'b0;
			tf_r   <= 1'b0;
			df_r   <= 1'b0;
			pass_r <= 1'b0;
		end else if (hif.bit_vld) begin
			prev_r <= hif.bit_val;
			run_r  <= same_w ? run_r + 8'h01 : 8'h00;
			if (stuck_w)
				tf_r <= 1'b1;
			pass_r <= 1'b0;
			if (win_end_w) begin
				bits_r <= 8'h00;
				ones_r <= 8'h00;
				if (bad_win_w)
					df_r <= 1'b1;
				else
					pass_r <= 1'b1;
			end else begin
				bits_r <= bits_r + 8'h01;
				ones_r <= ones_nxt;
			end
		end else begin
			pass_r <= 1'b0;
		end
	end

	assign hif.total_fail = tf_r;
	assign hif.defect     = df_r;
	assign hif.win_pass   = pass_r;

	AST_TF_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n)
		tf_r |=> tf_r) else $error("total failure flag dropped");
	AST_DF_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n)
		df_r |=> df_r) else $error("defect flag dropped");
endmodule : ehg_health

//--- design/ehg_gate.sv
// Health-gated random word output controller
`timescale 1ns/1ps
`include "ehg_params.svh"
module ehg_gate (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   raw_bit_i,
	input  wire logic                   raw_vld_i,
	input  wire logic                   hybrid_mode_i,
	input  wire logic                   rd_i,
	output logic [`EHG_WORD_W-1:0]      rnd_word_o,
	output logic                        rnd_vld_o,
	output logic                        total_fail_o,
	output logic                        defect_o,
	output logic                        ready_o
);
	// ----------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;
	logic [1:0] bit_sync_r;
	logic [1:0] vld_sync_r;
	logic [1:0] mode_sync_r;
	logic       vld_prev_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_sync_r  <= 2'b00;
			vld_sync_r  <= 2'b00;
			mode_sync_r <= 2'b00;
			vld_prev_r  <= 1'b0;
		end else begin
			bit_sync_r  <= {bit_sync_r[0], raw_bit_i};
			vld_sync_r  <= {vld_sync_r[0], raw_vld_i};
			mode_sync_r <= {mode_sync_r[0], hybrid_mode_i};
			vld_prev_r  <= vld_sync_r[1];
		end
	end

	// Raw strobe is a level toggling per bit; edge marks a new bit
	wire bit_stb_w = vld_sync_r[1] ^ vld_prev_r;
	wire hybrid_w  = mode_sync_r[1];

	ehg_health_if hif ();
	assign hif.bit_vld = bit_stb_w;
	assign hif.bit_val = bit_sync_r[1];

	ehg_health u_health (
		.clk_i (clk_i),
		.rst_n (rst_n),
		.hif   (hif)
	);

	// ----------------------------------------
	// Word assembly and gating
	// ----------------------------------------
	ehg_pkg::ehg_state_e state_r;
	ehg_pkg::ehg_state_e state_nxt;
	logic [`EHG_WORD_W-1:0] shift_r;
	logic [4:0]             nbit_r;
	logic [`EHG_WORD_W-1:0] word_r;
	logic                   vld_r;
	logic [`EHG_CNT_W-1:0]  pass_cnt_r;
	logic [`EHG_CNT_W-1:0]  seed_cnt_r;
	logic                   tf_r;
	logic                   df_r;
	logic                   rdy_r;

	wire fail_w    = hif.total_fail || hif.defect;
	wire word_done = bit_stb_w && (nbit_r == 5'h1f);
	wire [`EHG_WORD_W-1:0] shift_nxt = {shift_r[`EHG_WORD_W-2:0],
		bit_sync_r[1]};
	wire tests_ok  = pass_cnt_r >= `EHG_TEST_WINDOWS;
	wire seed_ok   = seed_cnt_r >= `EHG_SEED_WORDS;
	// Seeding words are absorbed, so output rate never exceeds input rate
	wire seed_need = hybrid_w && !seed_ok;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ehg_pkg::EHG_ST_STARTUP: begin
				if (fail_w)
					state_nxt = ehg_pkg::EHG_ST_BLOCKED;
				else if (tests_ok)
					state_nxt = hybrid_w ? ehg_pkg::EHG_ST_SEED
						: ehg_pkg::EHG_ST_RUN;
			end
			ehg_pkg::EHG_ST_SEED: begin
				if (fail_w)
					state_nxt = ehg_pkg::EHG_ST_BLOCKED;
				else if (seed_ok)
					state_nxt = ehg_pkg::EHG_ST_RUN;
			end
			ehg_pkg::EHG_ST_RUN: begin
				if (fail_w)
					state_nxt = ehg_pkg::EHG_ST_BLOCKED;
			end
			ehg_pkg::EHG_ST_BLOCKED: begin
				state_nxt = ehg_pkg::EHG_ST_BLOCKED;
			end
		endcase
	end

	wire run_w = (state_r == ehg_pkg::EHG_ST_RUN) && !fail_w;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ehg_pkg::EHG_ST_STARTUP;
			shift_r    <= 32'h0000_0000;
			nbit_r     <= 5'h00;
			pass_cnt_r <= 8'h00;
			seed_cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (bit_stb_w) begin
				shift_r <= shift_nxt;
				nbit_r  <= nbit_r + 5'h01;
			end
			if (hif.win_pass && !tests_ok)
				pass_cnt_r <= pass_cnt_r + 8'h01;
			// One seed word per raw word
			if (word_done && state_r == ehg_pkg::EHG_ST_SEED && seed_need)
				seed_cnt_r <= seed_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			word_r <= 32'h0000_0000;
			vld_r  <= 1'b0;
		end else begin
			if (fail_w || state_r == ehg_pkg::EHG_ST_BLOCKED) begin
				vld_r  <= 1'b0;
				word_r <= 32'h0000_0000;
			end else if (word_done && run_w) begin
				vld_r  <= 1'b1;
				word_r <= shift_nxt;
			end else if (rd_i) begin
				vld_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tf_r  <= 1'b0;
			df_r  <= 1'b0;
			rdy_r <= 1'b0;
		end else begin
			tf_r  <= hif.total_fail;
			df_r  <= hif.defect;
			rdy_r <= run_w;
		end
	end

	assign rnd_word_o   = word_r;
	assign rnd_vld_o    = vld_r;
	assign total_fail_o = tf_r;
	assign defect_o     = df_r;
	assign ready_o      = rdy_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_NO_OUT_BEFORE_PASS: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		!tests_ok |=> !vld_r) else $error("word before power-up pass");
	AST_TF_BLOCKS: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		hif.total_fail |=> !vld_r) else $error("word after total failure");
	AST_DEFECT_BLOCKS: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		hif.defect |=> !vld_r) else $error("word after defect");
	AST_SEED_FIRST: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		(hybrid_w && !seed_ok) |=> !vld_r) else $error("word before seed");
	AST_BLOCK_STICKY: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		state_r == ehg_pkg::EHG_ST_BLOCKED |=>
		state_r == ehg_pkg::EHG_ST_BLOCKED) else $error("left blocked");
	AST_FLAG_MIRROR: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		hif.total_fail |=> tf_r) else $error("fail flag not shown");
	AST_WORD_HOLD: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		(vld_r && !rd_i && !fail_w && !word_done) |=> $stable(word_r))
		else $error("word changed while held");
	AST_RATE: assert property (@(posedge clk_i)
		disable iff (!rst_n)
		$rose(vld_r) |-> $past(bit_stb_w)) else $error("word without input");
endmodule : ehg_gate

//--- dv/ehg_consumer.sv
// Consumer model taking each valid random word
`timescale 1ns/1ps
`include "ehg_params.svh"
module ehg_consumer (
	input  wire logic                   clk_i,
	input  wire logic                   vld_i,
	input  wire logic [`EHG_WORD_W-1:0] word_i,
	input  wire logic [1:0]             lag_i,
	output logic                        rd_o,
	output logic                        got_o,
	output logic [`EHG_WORD_W-1:0]      word_o
);
	logic [1:0] wait_r = 2'h0;
	initial rd_o = 1'b0;
	initial got_o = 1'b0;
	always @(posedge clk_i) begin
		rd_o <= 1'b0;
		got_o <= 1'b0;
		if (vld_i && !rd_o) begin
			wait_r <= wait_r + 2'h1;
			if (wait_r >= lag_i) begin
				rd_o <= 1'b1;
				got_o <= 1'b1;
				word_o <= word_i;
				wait_r <= 2'h0;
			end
		end
	end
endmodule : ehg_consumer

//--- dv/entropy_health_gated_rng_tb.sv
// Testbench for the health-gated random word block
`timescale 1ns/1ps
`include "ehg_params.svh"
module entropy_health_gated_rng_tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, raw_bit_i = 1'b0, raw_vld_i = 1'b0;
	logic hybrid_mode_i = 1'b0, rd_i, rnd_vld_o, total_fail_o, defect_o;
	logic ready_o, got;
	logic [`EHG_WORD_W-1:0] rnd_word_o, word, cur, last;
	logic [1:0] lag = 2'h0;
	int failures = 0, total_checks = 0, nbits, nwords, snap;

	always #2 clk_i = ~clk_i;

	ehg_gate dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .raw_bit_i(raw_bit_i),
		.raw_vld_i(raw_vld_i), .hybrid_mode_i(hybrid_mode_i), .rd_i(rd_i),
		.rnd_word_o(rnd_word_o), .rnd_vld_o(rnd_vld_o),
		.total_fail_o(total_fail_o), .defect_o(defect_o), .ready_o(ready_o));
	ehg_consumer cons_u (.clk_i(clk_i), .vld_i(rnd_vld_o),
		.word_i(rnd_word_o), .lag_i(lag), .rd_o(rd_i), .got_o(got),
		.word_o(word));

	task automatic check(string nm, logic [31:0] exp, logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	always @(posedge clk_i) if (got === 1'b1) begin
		nwords++;
		check("word", last, word);
	end

	task automatic do_reset(input logic hyb, input logic [1:0] lg);
		#1 rst_n_i = 1'b0;
		raw_vld_i = 1'b0;
		hybrid_mode_i = hyb;
		lag = lg;
		repeat (10) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		nbits = 0;
		nwords = 0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : do_reset

	// Bit held three cycles around each toggle for the sync stage
	task automatic send(input logic b);
		raw_bit_i = b;
		repeat (3) @(posedge clk_i);
		#1 raw_vld_i = ~raw_vld_i;
		cur = {cur[30:0], b};
		nbits++;
		if (nbits % 32 == 0) last = cur;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : send

	// Balanced pattern with short runs (mode 0), or one-in-four ones pattern (mode 1)
	task automatic pat(input int n, input int mode);
		int k;
		for (k = 0; k < n; k++) begin
			if (mode == 0) send(k[0] ^ k[2] ^ k[5]);
			else send(k % 4 == 0);
		end
		repeat (8) @(posedge clk_i);
		#1 snap = nwords;
	endtask : pat

	task automatic t_phys;
		int s0;
		do_reset(1'b0, 2'h2);
		pat(480, 0);
		check("early words", 0, nwords);
		check("early ready", 0, ready_o);
		pat(320, 0);
		check("run words", 1, nwords > 4);
		check("ready", 1, ready_o);
		s0 = snap;
		repeat (32) send(1'b1);
		pat(0, 0);
		check("fail", 1, total_fail_o);
		check("fail words", s0, nwords);
		check("defect", 0, defect_o);
		pat(100, 0);
		check("blocked", snap, nwords);
		$display("test phys done");
	endtask : t_phys

	task automatic t_defect;
		do_reset(1'b0, 2'h0);
		pat(544, 0);
		pat(320, 1);
		check("defect", 1, defect_o);
		check("no fail", 0, total_fail_o);
		check("ready off", 0, ready_o);
		pat(64, 0);
		check("defect words", snap, nwords);
		$display("test defect done");
	endtask : t_defect

	task automatic t_hybrid;
		do_reset(1'b1, 2'h0);
		pat(736, 0);
		check("seed words", 0, nwords);
		pat(96, 0);
		check("hyb words", 1, nwords > 0);
		do_reset(1'b1, 2'h0);
		repeat (40) send(1'b0);
		pat(0, 0);
		check("start fail", 1, total_fail_o);
		pat(600, 0);
		check("start block", 0, nwords);
		$display("test hybrid done");
	endtask : t_hybrid

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial begin
		t_phys();
		t_defect();
		t_hybrid();
		summarize();
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		summarize();
	end
endmodule : entropy_health_gated_rng_tb
